// *** tb/ebs_brake_model.sv ***
// Brake model: contact follows the coil after a travel time
`timescale 1ns/1ps
`default_nettype none
module ebs_brake_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Coil and contact
  input wire logic brake_release_out,
  output logic brake_confirm_in
);
  logic [3:0] travel;
  // Contact lags the coil, so a zero confirm timeout must trip
  always_ff @(posedge core_clk) begin
    travel <= rst ? 4'h0 : {travel[2:0], brake_release_out};
    brake_confirm_in <= rst ? 1'b0 : travel[3];
  end
endmodule
`default_nettype wire

// *** tb/ebs_seq_chk.sv ***
// Assertion checker for the brake sequencer
`timescale 1ns/1ps
`default_nettype none
module ebs_seq_chk
  import ebs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Watched ports
  input wire logic [7:0] brake_ctrl_enable,
  input wire logic [7:0] confirm_input_func,
  input wire logic [FREQ_W-1:0] release_frequency,
  input wire logic [CUR_W-1:0] release_current,
  input wire logic [CUR_W-1:0] output_current,
  input wire logic [FREQ_W-1:0] freq_limit,
  input wire logic trip,
  input wire logic brake_release_out,
  input wire logic brake_error_out,
  input wire logic [3:0] seq_state
);
  logic [FREQ_W-1:0] rel_clamp;
  // Setting above the top of range is clamped by the sequencer
  assign rel_clamp = (release_frequency > FREQ_MAX) ? FREQ_MAX : release_frequency;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_rel_rise;
    $rose(brake_release_out);
  endsequence
  a_off_no_release: assert property (brake_ctrl_enable != ENABLE_CODE |=> !brake_release_out)
    else $error("release while disabled");
  a_ramp_to_release: assert property (seq_state == EBS_RAMP_UP |-> freq_limit == rel_clamp)
    else $error("ramp limit not release frequency");
  a_release_state: assert property (s_rel_rise |-> seq_state inside {EBS_CONF_ON, EBS_ACC_WAIT})
    else $error("release in wrong state");
  a_low_current_trip: assert property (seq_state == EBS_REL_WAIT && output_current < release_current
    && brake_ctrl_enable == ENABLE_CODE |=> seq_state == EBS_TRIP && brake_error_out)
    else $error("low current did not trip");
  a_trip_holds_brake: assert property (trip |-> !brake_release_out && brake_error_out)
    else $error("trip without error or with release");
  a_confirm_hold: assert property (seq_state == EBS_CONF_ON |-> freq_limit == rel_clamp)
    else $error("accelerated before confirmation");
  a_no_timeout_trip: assert property (confirm_input_func != CONFIRM_FUNC && !trip
    && seq_state != EBS_REL_WAIT |=> !trip)
    else $error("timeout trip without confirm input");
  a_stop_hold: assert property (seq_state == EBS_CONF_OFF
    |-> !brake_release_out && freq_limit == rel_clamp)
    else $error("stop wait not holding release frequency");
  a_zero_limit: assert property (seq_state == EBS_TO_ZERO |-> freq_limit == FREQ_ZERO)
    else $error("final ramp not to zero");
endmodule
bind ebs_seq ebs_seq_chk u_ebs_seq_chk (.core_clk(core_clk), .rst(rst),
  .brake_ctrl_enable(brake_ctrl_enable), .confirm_input_func(confirm_input_func),
  .release_frequency(release_frequency), .release_current(release_current),
  .output_current(output_current), .freq_limit(freq_limit), .trip(trip),
  .brake_release_out(brake_release_out), .brake_error_out(brake_error_out), .seq_state(seq_state));
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the brake sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ebs_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] en = 8'h00;
  logic [7:0] func = 8'h00;
  logic trip_reset = 1'b0;
  logic run_cmd = 1'b0;
  logic [CUR_W-1:0] cur = 8'h64;
  logic [CUR_W-1:0] thr = 8'h32;
  logic [FREQ_W-1:0] rf = 16'h01F4;
  logic [FREQ_W-1:0] tf = 16'h0BB8;
  logic [FREQ_W-1:0] ofreq = 16'h0000;
  logic [FREQ_W-1:0] freq_limit;
  logic drive_on, trip, conf, rel, berr;
  logic [3:0] seq_state;
  int n_fail = 0;
  int total_checks = 0;
  always #12.5 core_clk = ~core_clk;
  // Drive reaches its limit in one cycle; a real ramp only stretches the steps
  always_ff @(posedge core_clk) ofreq <= drive_on ? freq_limit : FREQ_ZERO;
  ebs_brake_model u_ebs_brake_model (.core_clk(core_clk), .rst(rst),
    .brake_release_out(rel), .brake_confirm_in(conf));
  // Delays are 0: one 10 ms tick would outlast the run
  ebs_seq u_ebs_seq (.core_clk(core_clk), .rst(rst), .brake_ctrl_enable(en),
    .release_wait_time(9'h000), .accel_wait_time(9'h000), .stop_wait_time(9'h000),
    .confirm_timeout(9'h000), .release_frequency(rf), .release_current(thr),
    .confirm_input_func(func), .trip_reset(trip_reset), .run_cmd(run_cmd),
    .target_frequency(tf), .output_frequency(ofreq), .output_current(cur),
    .freq_limit(freq_limit), .drive_on(drive_on), .trip(trip), .brake_confirm_in(conf),
    .brake_release_out(rel), .brake_error_out(berr), .seq_state(seq_state));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_st(input logic [3:0] s);
    int i;
    for (i = 0; i < 60 && seq_state !== s; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk("seq_state", {12'h000, s}, {12'h000, seq_state});
  endtask
  task automatic results;
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    results;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    run_cmd <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    chk("freq_limit", tf, freq_limit);
    chk("brake_release_out", 16'h0000, {15'h0000, rel});
    chk("drive_on", 16'h0001, {15'h0000, drive_on});
    @(posedge core_clk);
    run_cmd <= 1'b0;
    repeat (8) @(posedge core_clk);
    en <= ENABLE_CODE;
    run_cmd <= 1'b1;
    wait_st(EBS_RAMP_UP);
    chk("freq_limit", rf, freq_limit);
    wait_st(EBS_RUN);
    chk("freq_limit", tf, freq_limit);
    chk("brake_release_out", 16'h0001, {15'h0000, rel});
    @(posedge core_clk);
    run_cmd <= 1'b0;
    wait_st(EBS_TO_ZERO);
    chk("freq_limit", FREQ_ZERO, freq_limit);
    chk("brake_release_out", 16'h0000, {15'h0000, rel});
    wait_st(EBS_IDLE);
    chk("trip", 16'h0000, {15'h0000, trip});
    @(posedge core_clk);
    func <= CONFIRM_FUNC;
    run_cmd <= 1'b1;
    wait_st(EBS_TRIP);
    chk("brake_error_out", 16'h0001, {15'h0000, berr});
    chk("drive_on", 16'h0000, {15'h0000, drive_on});
    @(posedge core_clk);
    run_cmd <= 1'b0;
    trip_reset <= 1'b1;
    wait_st(EBS_IDLE);
    chk("trip", 16'h0000, {15'h0000, trip});
    @(posedge core_clk);
    trip_reset <= 1'b0;
    func <= 8'h00;
    cur <= 8'h0A;
    run_cmd <= 1'b1;
    wait_st(EBS_TRIP);
    chk("brake_release_out", 16'h0000, {15'h0000, rel});
    chk("brake_error_out", 16'h0001, {15'h0000, berr});
    chk("freq_limit", FREQ_ZERO, freq_limit);
    results;
  end
endmodule
`default_nettype wire

// *** verilog/ebs_pkg.sv ***
// Constants and types for the external brake sequencer
package ebs_pkg;
  // Clock rate and timer tick
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W = 19;
  // Delay settings in ticks of 10 ms: 0.00 s to 5.00 s
  localparam int TIME_W = 9;
  localparam logic [TIME_W-1:0] TIME_MAX = 9'h1F4;
  // Frequency in hundredths of a hertz, 0.00 to 400.00 Hz
  localparam int FREQ_W = 16;
  localparam logic [FREQ_W-1:0] FREQ_ZERO = 16'h0000;
  localparam logic [FREQ_W-1:0] FREQ_MAX = 16'h9C40;
  // Current in percent of rated, 0 to 200
  localparam int CUR_W = 8;
  localparam logic [CUR_W-1:0] CUR_MAX = 8'hC8;
  // Enable code and confirmation input function code
  localparam logic [7:0] ENABLE_CODE = 8'h01;
  localparam logic [7:0] CONFIRM_FUNC = 8'h2C;

  typedef enum logic [3:0] {
    EBS_IDLE = 4'b0000,
    EBS_RAMP_UP = 4'b0001,
    EBS_REL_WAIT = 4'b0010,
    EBS_CONF_ON = 4'b0011,
    EBS_ACC_WAIT = 4'b0100,
    EBS_RUN = 4'b0101,
    EBS_RAMP_DN = 4'b0110,
    EBS_CONF_OFF = 4'b0111,
    EBS_STOP_WAIT = 4'b1000,
    EBS_TO_ZERO = 4'b1001,
    EBS_TRIP = 4'b1010
  } ebs_state_t;
endpackage

// *** verilog/ebs_seq.sv ***
// External brake sequencer top
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RQ1] Sequencing only when enable setting is 01, else pass ramp through.
// [RQ2] On run, ramp up only to the release frequency.
// [RQ3] At release frequency wait release time, then assert brake release.
// [RQ4] Current below release threshold: no release, trip, brake error.
// [RQ5] While awaiting confirmation, hold release frequency.
// [RQ6] After confirmation on, wait accel time, then accelerate to target.
// [RQ7] Without confirm input, accel delay counts from brake release.
// [RQ8] Without confirm input, confirmation timeout is ignored.
// [RQ9] After release switches, confirmation must follow within timeout or trip.
// [RQ10] On run off, ramp down to release frequency, then drop release.
// [RQ11] Hold release frequency during stop wait; timeout trips with error.
// [RQ12] After confirm off, wait stop time, then decelerate to 0 Hz.
// [RQ13] Release frequency covers 0.00 to 400.0 Hz.
// [RQ14] Brake drives confirm on when released; input assigned by code 44.
// [RQ15] Timers count 10 ms ticks against programmed values.
module ebs_seq
  import ebs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Settings
  input wire logic [7:0] brake_ctrl_enable,
  input wire logic [TIME_W-1:0] release_wait_time,
  input wire logic [TIME_W-1:0] accel_wait_time,
  input wire logic [TIME_W-1:0] stop_wait_time,
  input wire logic [TIME_W-1:0] confirm_timeout,
  input wire logic [FREQ_W-1:0] release_frequency,
  input wire logic [CUR_W-1:0] release_current,
  input wire logic [7:0] confirm_input_func,
  input wire logic trip_reset,
  // Drive side
  input wire logic run_cmd,
  input wire logic [FREQ_W-1:0] target_frequency,
  input wire logic [FREQ_W-1:0] output_frequency,
  input wire logic [CUR_W-1:0] output_current,
  output logic [FREQ_W-1:0] freq_limit,
  output logic drive_on,
  output logic trip,
  // Brake side
  input wire logic brake_confirm_in,
  output logic brake_release_out,
  output logic brake_error_out,
  // Status
  output logic [3:0] seq_state
);
  ebs_state_t state;
  ebs_state_t next_state;
  logic tick;
  logic [TIME_W-1:0] timer;
  logic [TIME_W-1:0] conf_timer;
  logic conf_sync1, conf_sync2, run_sync1, run_sync2;
  logic enabled, has_confirm, timer_done, conf_expired, at_release;
  logic [FREQ_W-1:0] rel_freq;
  logic [FREQ_W-1:0] next_limit;
  logic next_drive, next_release, next_error;

  ebs_tick u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick)
  );

  // Contact pin comes from outside the clock domain
  always_ff @(posedge core_clk) begin
    if (rst) begin
      conf_sync1 <= 1'b0;
      conf_sync2 <= 1'b0;
    end else begin
      conf_sync1 <= brake_confirm_in;
      conf_sync2 <= conf_sync1;
    end
  end

  // Run command pin, same treatment
  always_ff @(posedge core_clk) begin
    if (rst) begin
      run_sync1 <= 1'b0;
      run_sync2 <= 1'b0;
    end else begin
      run_sync1 <= run_cmd;
      run_sync2 <= run_sync1;
    end
  end

  assign enabled = (brake_ctrl_enable == ENABLE_CODE); // [RQ1]
  assign has_confirm = (confirm_input_func == CONFIRM_FUNC); // [RQ14]
  // Out-of-range setting clamps rather than overflowing the ramp
  assign rel_freq = (release_frequency > FREQ_MAX) ? FREQ_MAX : release_frequency; // [RQ13]
  assign at_release = (output_frequency >= rel_freq);
  // Only delays are timed; the ramp itself is the drive's business
  assign timer_done = (timer >= release_wait_time) && (state == EBS_REL_WAIT) ||
                      (timer >= accel_wait_time) && (state == EBS_ACC_WAIT) ||
                      (timer >= stop_wait_time) && (state == EBS_STOP_WAIT); // [RQ15]
  assign conf_expired = has_confirm && (conf_timer >= confirm_timeout); // [RQ8] [RQ9]

  always_comb begin
    next_state = state;
    unique case (state)
      EBS_IDLE: if (enabled && run_sync2) next_state = EBS_RAMP_UP; // [RQ2]
      EBS_RAMP_UP: begin
        if (!run_sync2) next_state = EBS_TO_ZERO;
        else if (at_release) next_state = EBS_REL_WAIT;
      end
      EBS_REL_WAIT: begin
        if (output_current < release_current) next_state = EBS_TRIP; // [RQ4]
        else if (timer_done) next_state = has_confirm ? EBS_CONF_ON : EBS_ACC_WAIT; // [RQ3] [RQ7]
      end
      EBS_CONF_ON: begin
        if (conf_sync2) next_state = EBS_ACC_WAIT; // [RQ6]
        else if (conf_expired) next_state = EBS_TRIP; // [RQ9]
      end
      EBS_ACC_WAIT: if (timer_done) next_state = EBS_RUN; // [RQ6]
      EBS_RUN: if (!run_sync2) next_state = EBS_RAMP_DN; // [RQ10]
      EBS_RAMP_DN: begin
        if (output_frequency <= rel_freq) next_state = has_confirm ? EBS_CONF_OFF : EBS_STOP_WAIT;
      end
      EBS_CONF_OFF: begin
        if (!conf_sync2) next_state = EBS_STOP_WAIT; // [RQ12]
        else if (conf_expired) next_state = EBS_TRIP; // [RQ11]
      end
      EBS_STOP_WAIT: if (timer_done) next_state = EBS_TO_ZERO; // [RQ12]
      EBS_TO_ZERO: if (output_frequency == FREQ_ZERO) next_state = EBS_IDLE;
      EBS_TRIP: if (trip_reset && !run_sync2) next_state = EBS_IDLE;
      default: next_state = EBS_TRIP;
    endcase
    // Disabling mid-sequence drops back to plain ramps
    if (!enabled && state != EBS_TRIP) next_state = EBS_IDLE; // [RQ1]
  end

  always_ff @(posedge core_clk) begin
    if (rst) state <= EBS_IDLE;
    else state <= next_state;
  end

  // Delay timer restarts on every state change
  always_ff @(posedge core_clk) begin
    if (rst || next_state != state) timer <= '0;
    else if (tick && timer != TIME_MAX) timer <= timer + 1'b1; // [RQ15]
  end

  // Confirmation timer restarts on every state change, like the delay timer
  always_ff @(posedge core_clk) begin
    if (rst || next_state != state) conf_timer <= '0;
    else if (tick && conf_timer != TIME_MAX) conf_timer <= conf_timer + 1'b1; // [RQ9]
  end

  // Ceiling follows the state being entered, so it moves together with seq_state
  always_comb begin
    unique case (next_state)
      EBS_IDLE: next_limit = (enabled || !run_sync2) ? FREQ_ZERO : target_frequency; // [RQ1]
      EBS_RAMP_UP: next_limit = rel_freq; // [RQ2]
      EBS_REL_WAIT: next_limit = rel_freq; // [RQ3]
      EBS_CONF_ON: next_limit = rel_freq; // [RQ5]
      EBS_ACC_WAIT: next_limit = rel_freq; // [RQ6]
      EBS_RUN: next_limit = target_frequency; // [RQ6]
      EBS_RAMP_DN: next_limit = rel_freq; // [RQ10]
      EBS_CONF_OFF: next_limit = rel_freq; // [RQ11]
      EBS_STOP_WAIT: next_limit = rel_freq; // [RQ12]
      EBS_TO_ZERO: next_limit = FREQ_ZERO; // [RQ12]
      EBS_TRIP: next_limit = FREQ_ZERO; // [RQ4]
      default: next_limit = FREQ_ZERO;
    endcase
  end

  // Drive stays on through the brake steps; a trip drops it
  always_comb begin
    next_drive = (next_state != EBS_IDLE) && (next_state != EBS_TRIP);
    if (!enabled && run_sync2) next_drive = 1'b1; // [RQ1]
  end

  // Release only from the end of the arrival delay until back at release frequency
  always_comb begin
    unique case (next_state)
      EBS_CONF_ON, EBS_ACC_WAIT, EBS_RUN, EBS_RAMP_DN: next_release = 1'b1; // [RQ3] [RQ10]
      default: next_release = 1'b0;
    endcase
  end

  assign next_error = (next_state == EBS_TRIP); // [RQ4] [RQ9] [RQ11]

  always_ff @(posedge core_clk) begin
    if (rst) begin
      freq_limit <= FREQ_ZERO;
    end else begin
      freq_limit <= next_limit;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      drive_on <= 1'b0;
    end else begin
      drive_on <= next_drive;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      brake_release_out <= 1'b0;
    end else begin
      brake_release_out <= next_release;
    end
  end

  // Error and trip hold until cleared with run low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      brake_error_out <= 1'b0;
    end else begin
      brake_error_out <= next_error;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      trip <= 1'b0;
    end else begin
      trip <= next_error;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      seq_state <= 4'h0;
    end else begin
      seq_state <= next_state;
    end
  end
endmodule
`default_nettype wire

// *** verilog/ebs_tick.sv ***
// Prescaler giving one pulse every 10 ms
`timescale 1ns/1ps
`default_nettype none
module ebs_tick
  import ebs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Tick pulse
  output logic tick
);
  logic [TICK_W-1:0] count;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count == TICK_W'(TICK_CYCLES - 1)) begin
      count <= '0;
      tick <= 1'b1; // [RQ15]
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire
